// *** ase_map.svh ***
`ifndef ASE_MAP_SVH
`define ASE_MAP_SVH
`define ASE_ACC_W        32
`define ASE_HALF_W       16
`define ASE_DIV_SHIFT    15
`define ASE_ST1_W        16
`define ASE_ST1_SXM_BIT  10
`define ASE_ST1_C_BIT    9
`define ASE_ST1_XF_BIT   4
`define ASE_ST1_RST      16'h0000
`endif

// *** ase_pkg.sv ***
package ase_pkg;
  typedef enum logic [2:0] {
    ASE_OP_NONE = 3'h0,
    ASE_OP_SUBTRACT_WITH_BORROW = 3'h1,
    ASE_OP_SUBTRACT_HIGH_HALF = 3'h3,
    ASE_OP_CONDITIONAL_SUBTRACT = 3'h2,
    ASE_OP_SXF  = 3'h6
  } ase_op_t;
endpackage

// *** ase_exec.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ase_map.svh"
// Overview of operation
// - subtract_with_borrow: acc minus memory word minus inverted carry.
// - subtract_with_borrow clears carry when a borrow occurs.
// - subtract_high_half subtracts memory word from accumulator upper half.
// - subtract_high_half leaves the lower accumulator half untouched.
// - subtract_high_half clears carry on borrow, otherwise carry holds.
// - set_external_flag_op drives the external_flag pin and status bit high.
// - Second status register holds sign_extension_mode and external_flag.
module ase_exec
  import ase_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  // Operation request, same clock domain
  input  wire logic                  op_valid,
  input  wire ase_op_t               op_code,
  input  wire logic [15:0]           mem_word,
  // Status load from core
  input  wire logic                  st1_load,
  input  wire logic [15:0]           st1_wdata,
  // State
  output logic [31:0]                acc,
  output logic [15:0]                second_status_register,
  output logic                       external_flag,
  output logic                       op_done
);

  function automatic logic [32:0] sub33(input logic [31:0] a,
                                        input logic [31:0] b);
    sub33 = {1'b0, a} - {1'b0, b};
  endfunction

  logic        carry;
  logic        sign_extension_mode;
  logic [32:0] subtract_with_borrow_diff;
  logic [32:0] subtract_with_borrow_tmp;
  logic        subtract_with_borrow_borrow;
  logic [16:0] subtract_high_half_diff;
  logic [32:0] conditional_subtract_full;
  logic [31:0] conditional_subtract_diff;
  logic [31:0] next_acc;
  logic        next_carry;

  assign carry               = second_status_register[`ASE_ST1_C_BIT];
  assign sign_extension_mode = second_status_register[`ASE_ST1_SXM_BIT];

  // Two-step borrow so both subtrahend borrows are seen
  assign subtract_with_borrow_tmp    = sub33(acc, {16'h0000, mem_word});
  assign subtract_with_borrow_diff   = sub33(subtract_with_borrow_tmp[31:0], {31'h0, ~carry});
  assign subtract_with_borrow_borrow = subtract_with_borrow_tmp[32] | subtract_with_borrow_diff[32];
  assign subtract_high_half_diff   = {1'b0, acc[31:16]} - {1'b0, mem_word};
  // Divisor sits at bit 15, so 32 bits hold it without loss
  assign conditional_subtract_full   = sub33(acc, {1'b0, mem_word, 15'h0000});
  assign conditional_subtract_diff   = conditional_subtract_full[31:0];

  always_comb begin
    next_acc   = acc;
    next_carry = carry;
    case (op_code)
      ASE_OP_SUBTRACT_WITH_BORROW: begin
        next_acc   = subtract_with_borrow_diff[31:0];
        next_carry = ~subtract_with_borrow_borrow;
      end
      ASE_OP_SUBTRACT_HIGH_HALF: begin
        next_acc = {subtract_high_half_diff[15:0], acc[15:0]};
        if (subtract_high_half_diff[16]) begin
          next_carry = 1'b0;
        end
      end
      ASE_OP_CONDITIONAL_SUBTRACT: begin
        // Sign of raw difference, no saturation applied
        if (!conditional_subtract_diff[31]) begin
          next_acc = {conditional_subtract_diff[30:0], 1'b1};
        end else begin
          next_acc = {acc[30:0], 1'b0};
        end
        next_carry = ~conditional_subtract_full[32];
      end
      default: begin
        next_acc   = acc;
        next_carry = carry;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= 32'h0000_0000;
    end else if (clk_en && op_valid) begin
      acc <= next_acc;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      second_status_register <= `ASE_ST1_RST;
    end else if (clk_en) begin
      if (op_valid && op_code == ASE_OP_SXF) begin
        second_status_register[`ASE_ST1_XF_BIT] <= 1'b1;
      end else if (op_valid) begin
        second_status_register[`ASE_ST1_C_BIT] <= next_carry;
      end else if (st1_load) begin
        second_status_register <= st1_wdata;
      end
    end
  end

  // Pin mirrors the status bit, both set by the same event
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      external_flag <= 1'b0;
    end else if (clk_en) begin
      if (op_valid && op_code == ASE_OP_SXF) begin
        external_flag <= 1'b1;
      end else if (!op_valid && st1_load) begin
        external_flag <= st1_wdata[`ASE_ST1_XF_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_done <= 1'b0;
    end else if (clk_en) begin
      op_done <= op_valid;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_subtract_high_half_req;
    clk_en && op_valid && op_code == ASE_OP_SUBTRACT_HIGH_HALF;
  endsequence

  sequence s_subtract_with_borrow_req;
    clk_en && op_valid && op_code == ASE_OP_SUBTRACT_WITH_BORROW;
  endsequence

  sequence s_conditional_subtract_req;
    clk_en && op_valid && op_code == ASE_OP_CONDITIONAL_SUBTRACT;
  endsequence

  sequence s_sxf_req;
    clk_en && op_valid && op_code == ASE_OP_SXF;
  endsequence

  // Load is refused while an operation owns the cycle
  sequence s_load_req;
    clk_en && st1_load && !op_valid;
  endsequence


  a_subtract_with_borrow_result: assert property (clk_en && op_valid && op_code == ASE_OP_SUBTRACT_WITH_BORROW
    |=> acc == $past(acc) - {16'h0000, $past(mem_word)}
               - {31'h0, ~$past(carry)})
    else $error("subtract with borrow result wrong");
  a_subtract_with_borrow_borrow: assert property (clk_en && op_valid && op_code == ASE_OP_SUBTRACT_WITH_BORROW
    && {16'h0000, mem_word} + {31'h0, ~carry} > {1'b0, acc}
    |=> !carry)
    else $error("borrow did not clear carry");
  a_subtract_high_half_high: assert property (s_subtract_high_half_req
    |=> acc[31:16] == $past(acc[31:16]) - $past(mem_word))
    else $error("high half difference wrong");
  a_subtract_high_half_low_kept: assert property (s_subtract_high_half_req
    |=> acc[15:0] == $past(acc[15:0]))
    else $error("low half changed");
  a_subtract_high_half_carry: assert property ((s_subtract_high_half_req and mem_word <= acc[31:16])
    |=> carry == $past(carry))
    else $error("carry changed without borrow");
  a_subtract_high_half_borrow: assert property ((s_subtract_high_half_req and mem_word > acc[31:16])
    |=> !carry)
    else $error("borrow did not clear carry");
  a_sxf_sets: assert property (clk_en && op_valid && op_code == ASE_OP_SXF
    |=> external_flag && second_status_register[`ASE_ST1_XF_BIT])
    else $error("external flag not set");
  a_flag_mirror: assert property (##1
    external_flag == second_status_register[`ASE_ST1_XF_BIT])
    else $error("pin and status bit differ");
  a_conditional_subtract_step: assert property (clk_en && op_valid && op_code == ASE_OP_CONDITIONAL_SUBTRACT
    |=> acc[0] == !$past(conditional_subtract_diff[31]))
    else $error("division step quotient bit wrong");

  a_subtract_with_borrow_no_borrow: assert property ((s_subtract_with_borrow_req
    and {16'h0000, mem_word} + {31'h0, ~carry} <= {1'b0, acc})
    |=> carry)
    else $error("carry not set without borrow");
  a_conditional_subtract_carry: assert property (s_conditional_subtract_req
    |=> carry == ($past({1'b0, mem_word, 15'h0000}) <= $past(acc)))
    else $error("division step carry wrong");
  a_sxf_keeps_acc: assert property (s_sxf_req |=> acc == $past(acc))
    else $error("flag set changed accumulator");
  a_none_keeps: assert property (clk_en && op_valid
    && op_code == ASE_OP_NONE |=> acc == $past(acc))
    else $error("empty operation changed accumulator");
  a_status_load: assert property (s_load_req
    |=> second_status_register == $past(st1_wdata)
    && sign_extension_mode == $past(st1_wdata[`ASE_ST1_SXM_BIT]))
    else $error("status load wrong");

  // Freeze must hold every register, not only the accumulator
  a_freeze_state: assert property (!clk_en
    |=> $stable(acc) && $stable(second_status_register)
    && $stable(external_flag) && $stable(op_done))
    else $error("state moved while clock enable low");
  a_done_pulse: assert property (clk_en |=> op_done == $past(op_valid))
    else $error("done flag wrong");

endmodule
`default_nettype wire

// *** accumulator_subtract_exec_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module accumulator_subtract_exec_tb;
  import ase_pkg::*;
  logic        clk, rst_n, clk_en, op_valid, st1_load;
  logic        external_flag, op_done, e_done;
  ase_op_t     op_code;
  logic [15:0] mem_word, st1_wdata, second_status_register, e_st;
  logic [31:0] acc, e_acc;
  logic [32:0] d;
  int          num_errors, checked, seed, cyc;
  ase_op_t     ops [5] = '{ASE_OP_NONE, ASE_OP_SUBTRACT_WITH_BORROW, ASE_OP_SUBTRACT_HIGH_HALF,
                           ASE_OP_CONDITIONAL_SUBTRACT, ASE_OP_SXF};
  ase_exec uut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .op_valid(op_valid), .op_code(op_code), .mem_word(mem_word),
    .st1_load(st1_load), .st1_wdata(st1_wdata), .acc(acc),
    .second_status_register(second_status_register),
    .external_flag(external_flag), .op_done(op_done));
  always #10 clk = ~clk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Ceiling well above the 2010 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // Reference step for one edge, on the inputs held across it
  task automatic step;
    if (!clk_en) return;
    e_done = op_valid;
    if (op_valid) case (op_code)
      ASE_OP_SUBTRACT_WITH_BORROW: begin
        d = {1'b0, e_acc} - {17'h0, mem_word} - {32'h0, ~e_st[9]};
        e_acc = d[31:0];
        e_st[9] = ~d[32];
      end
      ASE_OP_SUBTRACT_HIGH_HALF: begin
        d = {17'h0, e_acc[31:16]} - {17'h0, mem_word};
        e_acc[31:16] = d[15:0];
        if (d[32]) e_st[9] = 1'b0;
      end
      ASE_OP_CONDITIONAL_SUBTRACT: begin
        d = {1'b0, e_acc} - {2'h0, mem_word, 15'h0};
        e_st[9] = ~d[32];
        e_acc = d[31] ? e_acc << 1 : {d[30:0], 1'b1};
      end
      ASE_OP_SXF: e_st[4] = 1'b1;
      default: ;
    endcase
    else if (st1_load) e_st = st1_wdata;
  endtask
  initial begin
    seed = 8311;
    clk = 0;
    rst_n = 0;
    clk_en = 0;
    op_valid = 0;
    op_code = ASE_OP_NONE;
    mem_word = 0;
    st1_load = 0;
    st1_wdata = 0;
    e_acc = 0;
    e_st = 0;
    e_done = 0;
    repeat (10) @(posedge clk);
    #1 rst_n = 1;
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk);
      #1;
      step();
      check(acc, e_acc);
      check(32'(second_status_register), 32'(e_st));
      check(32'(external_flag), 32'(e_st[4]));
      check(32'(op_done), 32'(e_done));
      // First cycles: every op back to back on all-zero and all-one words
      clk_en = i < 10 || $random(seed) % 8 != 0;
      op_valid = i < 10 || $random(seed) % 4 != 0;
      op_code = ops[i < 10 ? i % 5 : $unsigned($random(seed)) % 5];
      mem_word = i < 10 ? (i % 2 ? 16'hffff : 16'h0) : 16'($random(seed));
      st1_load = 1'($random(seed));
      st1_wdata = 16'($random(seed));
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
